// *** logic/sbie_pkg.sv ***
// package: register map, field positions and reset values of the block
// Behaviour
// - bit 7 gates transmit-empty request
// - bit 6 gates transmit-end request
// - transmit-end request drops with flag or enable
// - bit 5 gates receive-full and overrun requests
// - receive-full request drops with flag or enable
// - bit 4 gates no-ack and overrun requests
// - no-ack request drops with flags or enable
// - bit 3 gates stop-detect request
// - judge bit 0 ignores received acknowledge
// - judge 1 and ack 1 halts transfer
// - bit 1 holds received acknowledge, read-only
// - bit 0 sets acknowledge level sent
package sbie_pkg;
   // register byte addresses
   localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h000;
   localparam logic [11:0] ADDR_FLAGS = 12'h004;
   localparam logic [11:0] ADDR_EVT_STATUS = 12'h008;
   localparam logic [11:0] ADDR_EVT_MASK = 12'h00C;
   // enable register fields
   localparam int BIT_TX_EMPTY_EN = 7;
   localparam int BIT_TX_END_EN = 6;
   localparam int BIT_RX_FULL_EN = 5;
   localparam int BIT_NO_ACK_EN = 4;
   localparam int BIT_STOP_EN = 3;
   localparam int BIT_ACK_JUDGE = 2;
   localparam int BIT_ACK_RCVD = 1;
   localparam int BIT_ACK_SEND = 0;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [7:0] ENABLE_WMASK = 8'hFD;
   // request vector positions (flag and event layout)
   localparam int NUM_REQ = 6;
   localparam int REQ_TX_EMPTY = 0;
   localparam int REQ_TX_END = 1;
   localparam int REQ_RX_FULL = 2;
   localparam int REQ_OVERRUN = 3;
   localparam int REQ_NO_ACK = 4;
   localparam int REQ_STOP = 5;
   localparam logic [5:0] EVT_RESET = 6'h00;
endpackage

// *** logic/sbie_edge.sv ***
// module: rising-edge detector for a vector of same-clock levels
`timescale 1ns/1ps
module sbie_edge #(
   parameter int WIDTH = 6
) (
   input wire logic clk, // clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic [WIDTH-1:0] level, // levels to watch
   output logic [WIDTH-1:0] rise // one-cycle pulse per rising level
);
   logic [WIDTH-1:0] prev_r; // level one cycle back

   // history register, cleared so a level high at reset counts as a rise
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         prev_r <= '0;
      else
         prev_r <= level;
   end

   assign rise = level & ~prev_r;
endmodule // sbie_edge

// *** logic/sbie_top.sv ***
// module: interrupt-enable and acknowledge control with an APB slave
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
module sbie_top (
   input wire logic REF_CLK, // 10 MHz clock
   input wire logic RST_N, // synchronous reset, active low
   input wire logic PSEL, // apb select
   input wire logic PENABLE, // apb access phase
   input wire logic PWRITE, // apb direction, 1 = write
   input wire logic [11:0] PADDR, // apb byte address
   input wire logic [31:0] PWDATA, // apb write data
   output logic [31:0] PRDATA, // apb read data
   output logic PREADY, // apb ready
   output logic PSLVERR, // apb error, unmapped address
   input wire logic TX_BUF_EMPTY_FLAG, // status flag, same clock
   input wire logic TX_END_FLAG, // status flag, same clock
   input wire logic RX_BUF_FULL_FLAG, // status flag, same clock
   input wire logic NO_ACK_FLAG, // status flag, same clock
   input wire logic ARB_LOST_FLAG, // status flag, same clock
   input wire logic OVERRUN_FLAG, // status flag, same clock
   input wire logic STOP_DETECT_FLAG, // status flag, same clock
   input wire logic SYNC_FORMAT, // 1 = clocked synchronous format
   input wire logic TRANSMIT_MODE, // 1 = transmit mode
   input wire logic ACK_SAMPLE_STB, // pulse: ack bit sampled
   input wire logic ACK_SAMPLE_IN, // ack level from the bus pin
   output logic TX_EMPTY_IRQ, // transmit data empty request
   output logic TX_END_IRQ, // transmit end request
   output logic RX_FULL_IRQ, // receive full request
   output logic OVERRUN_ERR_IRQ, // overrun error request
   output logic NO_ACK_IRQ, // no-ack / arbitration request
   output logic STOP_DETECT_IRQ, // stop detected request
   output logic HALT_TRANSFER, // stop continuous transfer
   output logic ACK_TO_SEND, // level driven in ack clock
   output logic IRQ // summary event interrupt
);
   logic [7:0] enable_r; // enable register image
   logic [5:0] req_nxt; // combined request levels
   logic [5:0] req_r; // registered requests
   logic [5:0] flags; // raw source flag vector
   logic [5:0] req_rise; // new request edges
   logic [5:0] evt_r; // sticky event status
   logic [5:0] mask_r; // event mask
   logic halt_r; // halt output register
   logic ack_r; // ack-to-send output register
   logic irq_r; // summary interrupt register
   logic [31:0] prdata_r; // read data register
   logic pready_r; // ready register
   logic pslverr_r; // error register
   logic ack_pin_s1; // synchroniser stage 1
   logic ack_pin_s2; // synchroniser stage 2
   logic wr_en; // write access taken this edge
   logic rd_en; // read access taken this edge
   logic addr_ok; // address is mapped

   // decode of mapped offsets, used by the error path only; reads decode in their own case
   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == sbie_pkg::ADDR_IRQ_ENABLE) ||
               (a == sbie_pkg::ADDR_FLAGS) ||
               (a == sbie_pkg::ADDR_EVT_STATUS) ||
               (a == sbie_pkg::ADDR_EVT_MASK);
   endfunction

   // slave answers one cycle into the access phase; pready_r low
   // on the first access cycle gives exactly one wait state
   assign wr_en = PSEL && PENABLE && pready_r && PWRITE;
   assign rd_en = PSEL && PENABLE && pready_r && !PWRITE;
   assign addr_ok = mapped(PADDR);

   assign flags[sbie_pkg::REQ_TX_EMPTY] = TX_BUF_EMPTY_FLAG;
   assign flags[sbie_pkg::REQ_TX_END] = TX_END_FLAG;
   assign flags[sbie_pkg::REQ_RX_FULL] = RX_BUF_FULL_FLAG;
   assign flags[sbie_pkg::REQ_OVERRUN] = OVERRUN_FLAG;
   assign flags[sbie_pkg::REQ_NO_ACK] = NO_ACK_FLAG;
   assign flags[sbie_pkg::REQ_STOP] = STOP_DETECT_FLAG;

   // ack level comes off the bus pin, so it is synchronised first
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         ack_pin_s1 <= 1'b0;
         ack_pin_s2 <= 1'b0;
      end
      else
      begin
         ack_pin_s1 <= ACK_SAMPLE_IN;
         ack_pin_s2 <= ack_pin_s1;
      end
   end

   // apb handshake: pready pulses on the second access-phase cycle
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         pready_r <= 1'b0;
      else if (PSEL && PENABLE && !pready_r)
         pready_r <= 1'b1;
      else
         pready_r <= 1'b0;
   end

   // error flag presented together with pready
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         pslverr_r <= 1'b0;
      else if (PSEL && PENABLE && !pready_r)
         pslverr_r <= !addr_ok;
      else
         pslverr_r <= 1'b0;
   end

   // enable register; received-ack bit is hardware owned
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         enable_r <= sbie_pkg::ENABLE_RESET;
      else
      begin
         if (wr_en && PADDR == sbie_pkg::ADDR_IRQ_ENABLE)
            enable_r <= (PWDATA[7:0] & sbie_pkg::ENABLE_WMASK) |
                        (enable_r & ~sbie_pkg::ENABLE_WMASK);
         // the stored ack is refreshed only while transmitting
         if (ACK_SAMPLE_STB && TRANSMIT_MODE)
            enable_r[sbie_pkg::BIT_ACK_RCVD] <= ack_pin_s2;
      end
   end

   // request gating: each request is enable AND its flag(s), overrun terms only in synchronous format
   always_comb
   begin
      req_nxt = '0;
      req_nxt[sbie_pkg::REQ_TX_EMPTY] =
         enable_r[sbie_pkg::BIT_TX_EMPTY_EN] && TX_BUF_EMPTY_FLAG;
      // the flag itself is set on the ninth clock rise with buffer empty
      req_nxt[sbie_pkg::REQ_TX_END] =
         enable_r[sbie_pkg::BIT_TX_END_EN] && TX_END_FLAG;
      req_nxt[sbie_pkg::REQ_RX_FULL] =
         enable_r[sbie_pkg::BIT_RX_FULL_EN] && RX_BUF_FULL_FLAG;
      // overrun reports through either enable in synchronous format
      req_nxt[sbie_pkg::REQ_OVERRUN] = SYNC_FORMAT && OVERRUN_FLAG &&
         (enable_r[sbie_pkg::BIT_RX_FULL_EN] ||
          enable_r[sbie_pkg::BIT_NO_ACK_EN]);
      req_nxt[sbie_pkg::REQ_NO_ACK] = enable_r[sbie_pkg::BIT_NO_ACK_EN] &&
         (NO_ACK_FLAG || ARB_LOST_FLAG ||
          (SYNC_FORMAT && OVERRUN_FLAG));
      req_nxt[sbie_pkg::REQ_STOP] =
         enable_r[sbie_pkg::BIT_STOP_EN] && STOP_DETECT_FLAG;
   end

   // request outputs, registered so every output comes from a flop
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         req_r <= '0;
      else
         req_r <= req_nxt;
   end

   // continuous-transfer halt and ack level to drive
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         halt_r <= 1'b0;
         ack_r <= 1'b0;
      end
      else
      begin
         // with judgement off the received ack never stops a transfer
         halt_r <= enable_r[sbie_pkg::BIT_ACK_JUDGE] &&
                   enable_r[sbie_pkg::BIT_ACK_RCVD];
         ack_r <= enable_r[sbie_pkg::BIT_ACK_SEND];
      end
   end

   // edges of the request levels feed the sticky event register
   sbie_edge #(
      .WIDTH(sbie_pkg::NUM_REQ)
   ) u_edge (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .level(req_nxt),
      .rise(req_rise)
   );

   // sticky events, write one to clear; a new edge wins over the clear
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         evt_r <= sbie_pkg::EVT_RESET;
      else if (wr_en && PADDR == sbie_pkg::ADDR_EVT_STATUS)
         evt_r <= (evt_r & ~PWDATA[5:0]) | req_rise;
      else
         evt_r <= evt_r | req_rise;
   end

   // event mask, 1 lets the event reach the interrupt line
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         mask_r <= sbie_pkg::EVT_RESET;
      else if (wr_en && PADDR == sbie_pkg::ADDR_EVT_MASK)
         mask_r <= PWDATA[5:0];
   end

   // summary interrupt, one cycle behind the status bits
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         irq_r <= 1'b0;
      else
         irq_r <= |(evt_r & mask_r);
   end

   // read data, captured on the cycle before pready rises
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         prdata_r <= 32'h0000_0000;
      else if (PSEL && PENABLE && !pready_r && !PWRITE)
      begin
         case (PADDR)
            sbie_pkg::ADDR_IRQ_ENABLE: prdata_r <= {24'h000000, enable_r};
            sbie_pkg::ADDR_FLAGS: prdata_r <= {26'h0000000, req_r};
            sbie_pkg::ADDR_EVT_STATUS: prdata_r <= {26'h0000000, evt_r};
            sbie_pkg::ADDR_EVT_MASK: prdata_r <= {26'h0000000, mask_r};
            default: prdata_r <= 32'h0000_0000; // unmapped reads zero
         endcase
      end
   end

   assign PRDATA = prdata_r;
   assign PREADY = pready_r;
   assign PSLVERR = pslverr_r;
   assign TX_EMPTY_IRQ = req_r[sbie_pkg::REQ_TX_EMPTY];
   assign TX_END_IRQ = req_r[sbie_pkg::REQ_TX_END];
   assign RX_FULL_IRQ = req_r[sbie_pkg::REQ_RX_FULL];
   assign OVERRUN_ERR_IRQ = req_r[sbie_pkg::REQ_OVERRUN];
   assign NO_ACK_IRQ = req_r[sbie_pkg::REQ_NO_ACK];
   assign STOP_DETECT_IRQ = req_r[sbie_pkg::REQ_STOP];
   assign HALT_TRANSFER = halt_r;
   assign ACK_TO_SEND = ack_r;
   assign IRQ = irq_r;
   // rd_en is kept for symmetry of the decode; reads have no side effect
   logic unused_rd;
   assign unused_rd = rd_en;
endmodule // sbie_top

// *** verif/sbie_bus_model.sv ***
// far side model: a serial bus receiver answering the acknowledge clock
`timescale 1ns/1ps
module sbie_bus_model (
   input wire logic clk, // clock
   input wire logic rst_n, // reset, active low
   input wire logic send, // pulse: answer one acknowledge
   input wire logic ack_val, // acknowledge level to return
   output logic pin, // bus data line
   output logic stb // pulse: acknowledge bit sampled
);
   logic [1:0] cnt_r; // cycles left with the line driven
   // hold the line for three cycles so the sampled level is ours
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         cnt_r <= 2'h0;
      else if (send)
         cnt_r <= 2'h3;
      else if (cnt_r != 2'h0)
         cnt_r <= cnt_r - 2'h1;
   end
   // a released line floats to its pull-up, never the last value
   assign pin = (send || cnt_r != 2'h0) ? ack_val : 1'b1;
   assign stb = (cnt_r == 2'h1);
endmodule // sbie_bus_model

// *** verif/sbie_top_sva.sv ***
// checker: request gating and bus timing seen at the top ports
`timescale 1ns/1ps
module sbie_top_sva (
   input wire logic REF_CLK, // clock
   input wire logic RST_N, // reset
   input wire logic PSEL, // apb
   input wire logic PENABLE, // apb
   input wire logic PREADY, // apb
   input wire logic PSLVERR, // apb
   input wire logic TX_BUF_EMPTY_FLAG, // flag
   input wire logic TX_END_FLAG, // flag
   input wire logic RX_BUF_FULL_FLAG, // flag
   input wire logic NO_ACK_FLAG, // flag
   input wire logic ARB_LOST_FLAG, // flag
   input wire logic OVERRUN_FLAG, // flag
   input wire logic STOP_DETECT_FLAG, // flag
   input wire logic SYNC_FORMAT, // format
   input wire logic TX_EMPTY_IRQ, // request
   input wire logic TX_END_IRQ, // request
   input wire logic RX_FULL_IRQ, // request
   input wire logic OVERRUN_ERR_IRQ, // request
   input wire logic NO_ACK_IRQ, // request
   input wire logic STOP_DETECT_IRQ // request
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   // setup then access, answered after exactly one wait state
   sequence setup_s;
      PSEL && !PENABLE ##1 PSEL && PENABLE;
   endsequence
   apb_wait_a: assert property (setup_s |=> PREADY)
      else $error("ready not on second access cycle");
   slverr_ready_a: assert property (PSLVERR |-> PREADY && PSEL)
      else $error("error without ready");
   tx_empty_a: assert property (TX_EMPTY_IRQ
      |-> $past(TX_BUF_EMPTY_FLAG))
      else $error("tx empty request without flag");
   tx_end_a: assert property (!TX_END_FLAG |=> !TX_END_IRQ)
      else $error("tx end request stayed");
   rx_full_a: assert property (RX_FULL_IRQ |-> $past(RX_BUF_FULL_FLAG))
      else $error("rx full request without flag");
   rx_drop_a: assert property (!RX_BUF_FULL_FLAG |=> !RX_FULL_IRQ)
      else $error("rx full request stayed");
   no_ack_a: assert property (!(NO_ACK_FLAG || ARB_LOST_FLAG
      || OVERRUN_FLAG) |=> !NO_ACK_IRQ)
      else $error("no ack request stayed");
   overrun_cause_a: assert property (OVERRUN_ERR_IRQ
      |-> $past(SYNC_FORMAT && OVERRUN_FLAG))
      else $error("overrun request without cause");
   stop_flag_a: assert property (STOP_DETECT_IRQ
      |-> $past(STOP_DETECT_FLAG))
      else $error("stop request without flag");
endmodule // sbie_top_sva
bind sbie_top sbie_top_sva chk (.*);

// *** verif/sbie_top_test.sv ***
// testbench: register access, request gating and acknowledge control
`timescale 1ns/1ps
module sbie_top_test;
   logic clk = 1'b0; // bench clock
   logic rst_n = 1'b0; // reset, active low
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0; // apb controls
   logic [11:0] paddr = 12'h000; // apb address
   logic [31:0] pwdata = 32'h0, prdata, rd; // apb data
   logic pready, pslverr, err, halt, ack_send, irq, pin, stb; // outputs
   logic [6:0] flg = 7'h00; // stop, ovr, arb, nack, rx, end, empty
   logic sync = 1'b0, txm = 1'b0, send = 1'b0, aval = 1'b0; // mode
   logic [5:0] req; // request levels in event layout
   logic [5:0] exp_t[5] = '{6'h01, 6'h02, 6'h0C, 6'h18, 6'h20}; // table
   int fail_count = 0, samples_checked = 0; // tallies
   always #50 clk = ~clk;
   sbie_bus_model far (.clk(clk), .rst_n(rst_n), .send(send),
      .ack_val(aval), .pin(pin), .stb(stb));
   sbie_top uut (.REF_CLK(clk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .TX_BUF_EMPTY_FLAG(flg[0]), .TX_END_FLAG(flg[1]),
      .RX_BUF_FULL_FLAG(flg[2]), .NO_ACK_FLAG(flg[3]),
      .ARB_LOST_FLAG(flg[4]), .OVERRUN_FLAG(flg[5]),
      .STOP_DETECT_FLAG(flg[6]), .SYNC_FORMAT(sync),
      .TRANSMIT_MODE(txm), .ACK_SAMPLE_STB(stb), .ACK_SAMPLE_IN(pin),
      .TX_EMPTY_IRQ(req[0]), .TX_END_IRQ(req[1]), .RX_FULL_IRQ(req[2]),
      .OVERRUN_ERR_IRQ(req[3]), .NO_ACK_IRQ(req[4]),
      .STOP_DETECT_IRQ(req[5]), .HALT_TRANSFER(halt),
      .ACK_TO_SEND(ack_send), .IRQ(irq));
   // compare one result, counting it
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   // one apb transfer; entered at an edge, leaves one edge after release
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      // no cycle count assumed; only the watchdog ends a stuck wait
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   // settle flags, then let the requests follow
   task automatic wait2();
      repeat (2) @(posedge clk);
   endtask
   // far side answers one acknowledge; six edges cover sync and capture
   task automatic ack_pulse(logic v);
      aval <= v;
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // watchdog: the tests need about 120 cycles
   initial
   begin
      repeat (5000) @(posedge clk);
      fail_count++;
      finish_test();
   end
   initial
   begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("reset outputs", 32'h0, {23'h0, halt, ack_send, irq, req});
      apb(1'b0, sbie_pkg::ADDR_IRQ_ENABLE, 32'h0);
      chk("enable reset", 32'h0, rd);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped read", 32'h0, rd);
      $display("test reset done");
      flg <= 7'h7F;
      sync <= 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b1, sbie_pkg::ADDR_IRQ_ENABLE, 32'h80 >> i);
         wait2();
         chk("requests", {26'h0, exp_t[i]}, {26'h0, req});
      end
      sync <= 1'b0;
      flg <= 7'h30;
      apb(1'b1, sbie_pkg::ADDR_IRQ_ENABLE, 32'h30);
      wait2();
      chk("arb lost", 32'h10, {26'h0, req});
      flg <= 7'h00;
      apb(1'b1, sbie_pkg::ADDR_IRQ_ENABLE, 32'hF8);
      wait2();
      chk("withdrawn", 32'h0, {26'h0, req});
      $display("test gating done");
      apb(1'b0, sbie_pkg::ADDR_EVT_STATUS, 32'h0);
      chk("events", 32'h3F, rd);
      wait2();
      chk("masked irq", 32'h0, {31'h0, irq});
      apb(1'b1, sbie_pkg::ADDR_EVT_MASK, 32'h3F);
      wait2();
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b1, sbie_pkg::ADDR_EVT_STATUS, 32'h3F);
      apb(1'b0, sbie_pkg::ADDR_EVT_STATUS, 32'h0);
      chk("cleared", 32'h0, rd);
      chk("irq off", 32'h0, {31'h0, irq});
      $display("test events done");
      apb(1'b1, sbie_pkg::ADDR_IRQ_ENABLE, 32'h0);
      txm <= 1'b1;
      ack_pulse(1'b1);
      chk("ignored ack", 32'h0, {31'h0, halt});
      apb(1'b1, sbie_pkg::ADDR_IRQ_ENABLE, 32'h05);
      wait2();
      chk("halt", 32'h1, {31'h0, halt});
      chk("ack level", 32'h1, {31'h0, ack_send});
      apb(1'b0, sbie_pkg::ADDR_IRQ_ENABLE, 32'h0);
      chk("ack bit", 32'h07, rd);
      // a driven 0 differs from the pull-up, so the capture must be live
      ack_pulse(1'b0);
      chk("no halt on ack 0", 32'h0, {31'h0, halt});
      apb(1'b0, sbie_pkg::ADDR_IRQ_ENABLE, 32'h0);
      chk("ack bit 0", 32'h05, rd);
      // in receive mode the stored acknowledge must not move
      txm <= 1'b0;
      ack_pulse(1'b1);
      apb(1'b0, sbie_pkg::ADDR_IRQ_ENABLE, 32'h0);
      chk("ack kept in receive", 32'h05, rd);
      $display("test acknowledge done");
      finish_test();
   end
endmodule // sbie_top_test
